// file: hw/irq_defs.svh
// Constants of the vectored interrupt unit.
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

`define IRQ_NUM_SRC 8
`define IRQ_ADDR_W 4
`define IRQ_DATA_W 8
`define IRQ_PC_W 12

`define IRQ_OFS_FLAG 4'h0
`define IRQ_OFS_CLEAR 4'h1
`define IRQ_OFS_MASK 4'h2
`define IRQ_OFS_STAT 4'h3

`define IRQ_FLAG_RST 8'h00
`define IRQ_MASK_RST 8'h00

`define IRQ_BIT_TIMER 0
`define IRQ_BIT_EXT0 1
`define IRQ_BIT_EXT1 2
`define IRQ_BIT_CNT1 3
`define IRQ_BIT_CNT2 4
`define IRQ_BIT_HPW 5
`define IRQ_BIT_LPW 6
`define IRQ_BIT_PORT 7

`define IRQ_STAT_GIE 0
`define IRQ_STAT_BUSY 1
`define IRQ_STAT_SRC_LO 4

`define IRQ_VEC_BASE 12'h003
`define IRQ_VEC_STEP 12'h003

`endif

// file: hw/irq_edge_detect.sv
// Per-source falling edge detector.
`timescale 1ns/100ps
module irq_edge_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Levels in, one-cycle falls out.
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] prev_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // A low level at reset release is not an edge: prev starts low.
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    prev_reg[i] <= 1'b0;
                end else begin
                    prev_reg[i] <= level_in[i];
                end
            end
            assign fall_out[i] = prev_reg[i] & ~level_in[i];
        end
    endgenerate

endmodule : irq_edge_detect

// file: hw/irq_pkg.sv
// Types shared by the vectored interrupt unit and its core side.
package irq_pkg;

    // Sampled request lines, one per source.
    typedef struct packed {
        logic port_change;
        logic lpw_timer;
        logic hpw_timer;
        logic counter_two;
        logic counter_one;
        logic ext_request_one;
        logic ext_request_zero;
        logic free_timer;
    } irq_src_t;

    // Core sequencing events and live context.
    typedef struct packed {
        logic global_irq_on_instr;
        logic global_irq_off_instr;
        logic fetch_boundary;
        logic isr_return;
        logic [7:0] accumulator_reg;
        logic [7:0] status_word_reg;
    } core_req_t;

    // Saved context handed back at return.
    typedef struct packed {
        logic [7:0] accumulator_reg;
        logic [7:0] status_word_reg;
    } context_t;

    typedef enum logic {
        ST_IDLE,
        ST_SERVICE
    } disp_state_t;

endpackage : irq_pkg

// file: hw/vectored_interrupt_unit.sv
// Vectored interrupt unit: flags, mask, dispatch and context save.
`timescale 1ns/100ps
`include "irq_defs.svh"
module vectored_interrupt_unit #(
    parameter int NUM_SRC = `IRQ_NUM_SRC,
    parameter int PC_W = `IRQ_PC_W
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Request sources.
    input wire logic free_timer_ovf,
    input wire logic port5_bit4,
    input wire logic port5_bit5,
    input wire logic counter_one_unf,
    input wire logic counter_two_unf,
    input wire logic hpw_timer_unf,
    input wire logic lpw_timer_unf,
    input wire logic port_change,
    // Core sequencing.
    input wire irq_pkg::core_req_t core_req,
    output logic vector_take,
    output logic [PC_W-1:0] vector_addr,
    output logic restore_valid,
    output irq_pkg::context_t restore_ctx,
    // Register port.
    input wire logic [`IRQ_ADDR_W-1:0] reg_addr,
    input wire logic [`IRQ_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`IRQ_DATA_W-1:0] reg_rdata,
    // Interrupt line.
    output logic irq_out
);
    import irq_pkg::*;

    irq_src_t src;
    logic [NUM_SRC-1:0] fall;
    logic [NUM_SRC-1:0] irq_flag_reg;
    logic [NUM_SRC-1:0] irq_flag_next;
    logic [NUM_SRC-1:0] irq_mask_reg;
    logic [NUM_SRC-1:0] clear_bits;
    logic [NUM_SRC-1:0] pending;
    logic gie_reg;
    disp_state_t state_reg;
    logic [2:0] active_reg;
    logic [2:0] pick;
    logic dispatch;
    context_t saved_reg;

    // Source order matches the mask bit layout.
    always_comb begin
        src.free_timer = free_timer_ovf;
        src.ext_request_zero = port5_bit4;
        src.ext_request_one = port5_bit5;
        src.counter_one = counter_one_unf;
        src.counter_two = counter_two_unf;
        src.hpw_timer = hpw_timer_unf;
        src.lpw_timer = lpw_timer_unf;
        src.port_change = port_change;
    end

    irq_edge_detect #(
        .WIDTH(NUM_SRC)
    ) u_edge (
        .mclk(mclk),
        .arst_n(arst_n),
        .level_in(src),
        .fall_out(fall)
    );

    assign clear_bits = (reg_wr && reg_addr == `IRQ_OFS_CLEAR) ? reg_wdata[NUM_SRC-1:0] : '0;

    // A fall in the clearing cycle survives: set wins over clear.
    assign irq_flag_next = (irq_flag_reg & ~clear_bits) | (fall & irq_mask_reg);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flag_reg <= `IRQ_FLAG_RST;
        end else begin
            irq_flag_reg <= irq_flag_next;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_reg <= `IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == `IRQ_OFS_MASK) begin
            irq_mask_reg <= reg_wdata[NUM_SRC-1:0];
        end
    end

    // Off wins if both instructions retire together, as the safer outcome.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gie_reg <= 1'b0;
        end else if (core_req.global_irq_off_instr) begin
            gie_reg <= 1'b0;
        end else if (core_req.global_irq_on_instr) begin
            gie_reg <= 1'b1;
        end
    end

    assign pending = irq_flag_reg & irq_mask_reg;
    assign irq_out = |pending;

    function automatic logic [2:0] lowest(input logic [NUM_SRC-1:0] v);
        logic [2:0] r;
        r = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction : lowest

    assign pick = lowest(pending);
    // Flags stay set while busy, so later requests wait for the return.
    assign dispatch = (state_reg == ST_IDLE) && gie_reg && (|pending)
        && core_req.fetch_boundary;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (dispatch) begin
                        state_reg <= ST_SERVICE;
                    end
                end
                ST_SERVICE: begin
                    if (core_req.isr_return) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vector_take <= 1'b0;
            vector_addr <= '0;
            active_reg <= '0;
        end else begin
            vector_take <= dispatch;
            if (dispatch) begin
                active_reg <= pick;
                vector_addr <= PC_W'(`IRQ_VEC_BASE + `IRQ_VEC_STEP * pick);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            saved_reg <= '0;
        end else if (dispatch) begin
            saved_reg.accumulator_reg <= core_req.accumulator_reg;
            saved_reg.status_word_reg <= core_req.status_word_reg;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            restore_valid <= 1'b0;
            restore_ctx <= '0;
        end else begin
            restore_valid <= (state_reg == ST_SERVICE) && core_req.isr_return;
            if ((state_reg == ST_SERVICE) && core_req.isr_return) begin
                restore_ctx <= saved_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `IRQ_OFS_FLAG: reg_rdata <= irq_flag_reg;
                `IRQ_OFS_MASK: reg_rdata <= irq_mask_reg;
                `IRQ_OFS_STAT: begin
                    reg_rdata <= '0;
                    reg_rdata[`IRQ_STAT_GIE] <= gie_reg;
                    reg_rdata[`IRQ_STAT_BUSY] <= (state_reg == ST_SERVICE);
                    reg_rdata[`IRQ_STAT_SRC_LO +: 3] <= active_reg;
                end
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_flag_set;
        (fall & irq_mask_reg) != '0 |=> (irq_flag_reg & $past(fall & irq_mask_reg))
            == $past(fall & irq_mask_reg);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("masked fall did not set flag");

    property p_flag_hold;
        (clear_bits == '0) |=> (irq_flag_reg & $past(irq_flag_reg)) == $past(irq_flag_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

    property p_unmasked_quiet;
        (clear_bits == '0 && (fall & ~irq_mask_reg) != '0 && irq_flag_reg == '0
            && (fall & irq_mask_reg) == '0) |=> irq_flag_reg == '0;
    endproperty
    a_unmasked_quiet: assert property (p_unmasked_quiet) else $error("masked-off source set");

    property p_vector;
        dispatch |=> vector_take && vector_addr == PC_W'(3 * ($past(pick) + 1));
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_no_dispatch_off;
        !gie_reg |=> !vector_take;
    endproperty
    a_no_dispatch_off: assert property (p_no_dispatch_off) else $error("dispatch while off");

    property p_no_nest;
        vector_take |-> !dispatch until core_req.isr_return;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("nested dispatch");

    property p_lowest;
        dispatch |-> (pending & ((NUM_SRC'(1) << pick) - NUM_SRC'(1))) == '0;
    endproperty
    a_lowest: assert property (p_lowest) else $error("not lowest pending");

    // Context seen at the dispatch edge; no dispatch can move it before the return.
    logic [15:0] ctx_chk_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctx_chk_reg <= 16'h0000;
        end else if (dispatch) begin
            ctx_chk_reg <= {core_req.accumulator_reg, core_req.status_word_reg};
        end
    end

    property p_restore;
        (state_reg == ST_SERVICE) && core_req.isr_return |=> restore_valid
            && restore_ctx == ctx_chk_reg;
    endproperty
    a_restore: assert property (p_restore) else $error("context not restored");

    property p_irq_out;
        irq_out == ((irq_flag_reg & irq_mask_reg) != '0);
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq line mismatch");

    property p_clear;
        (clear_bits & ~(fall & irq_mask_reg)) != '0
            |=> (irq_flag_reg & $past(clear_bits & ~(fall & irq_mask_reg))) == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared by write");

    property p_mask_hold;
        !(reg_wr && reg_addr == `IRQ_OFS_MASK) |=> $stable(irq_mask_reg);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved without write");

    property p_gie_hold;
        !core_req.global_irq_on_instr && !core_req.global_irq_off_instr |=> $stable(gie_reg);
    endproperty
    a_gie_hold: assert property (p_gie_hold) else $error("global enable moved alone");

    property p_take_pulse;
        vector_take |=> !vector_take;
    endproperty
    a_take_pulse: assert property (p_take_pulse) else $error("take held over");

    property p_busy_hold;
        state_reg == ST_SERVICE && !core_req.isr_return |=> state_reg == ST_SERVICE;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("service ended early");

    property p_return_idle;
        restore_valid |-> state_reg == ST_IDLE;
    endproperty
    a_return_idle: assert property (p_return_idle) else $error("busy after restore");

    property p_vector_hold;
        !dispatch |=> $stable(vector_addr);
    endproperty
    a_vector_hold: assert property (p_vector_hold) else $error("vector moved alone");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    c_dispatch: cover property (dispatch ##1 vector_take);
    c_return: cover property (vector_take ##[1:20] restore_valid);
    c_held: cover property (state_reg == ST_SERVICE && (fall & irq_mask_reg) != '0);
    c_set_clear: cover property ((clear_bits & fall & irq_mask_reg) != '0);
    c_redispatch: cover property (restore_valid ##[1:8] vector_take);

endmodule : vectored_interrupt_unit

// file: sim/core_model.sv
// Core-side partner: instruction boundaries, routine length and live context.
`timescale 1ns/100ps
module core_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Commands from the bench.
    input wire logic on_cmd,
    input wire logic off_cmd,
    input wire logic slow,
    input wire logic [3:0] svc_len,
    input wire logic [7:0] acc_seed,
    input wire logic [7:0] st_seed,
    // Unit side.
    input wire logic vector_take,
    output irq_pkg::core_req_t core_req
);
    import irq_pkg::*;
    logic [3:0] cnt_reg;
    logic [1:0] tick_reg;

    // A slow core reaches an instruction boundary only one cycle in four.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) tick_reg <= 2'h0;
        else tick_reg <= tick_reg + 2'h1;
    end

    // The routine runs svc_len cycles after the take; keep svc_len above zero.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) cnt_reg <= 4'h0;
        else if (vector_take) cnt_reg <= svc_len;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end

    assign core_req.global_irq_on_instr = on_cmd;
    assign core_req.global_irq_off_instr = off_cmd;
    assign core_req.fetch_boundary = !slow || (tick_reg == 2'h0);
    assign core_req.isr_return = (cnt_reg == 4'h1);
    // The routine clobbers the context, so a late save shows up at restore.
    assign core_req.accumulator_reg = (cnt_reg != 4'h0) ? ~acc_seed : acc_seed;
    assign core_req.status_word_reg = (cnt_reg != 4'h0) ? (st_seed ^ 8'h5a) : st_seed;
endmodule : core_model

// file: sim/tb.sv
// Self-checking bench for the vectored interrupt unit.
`timescale 1ns/100ps
`include "irq_defs.svh"
module tb;
    import irq_pkg::*;
    logic mclk, arst_n, on_cmd, off_cmd, slow, reg_wr, reg_rd, rd_d;
    logic vector_take, restore_valid, irq_out;
    logic [7:0] src, acc_seed, st_seed, reg_wdata, reg_rdata, r, m;
    logic [3:0] svc_len, reg_addr;
    logic [11:0] vector_addr;
    core_req_t core_req;
    context_t restore_ctx;
    int failures, n_compared, seed, i, k;
    logic [15:0] exp_rd[$], exp_vec[$], exp_ctx[$];

    vectored_interrupt_unit vectored_interrupt_unit_inst (.mclk(mclk), .arst_n(arst_n),
        .free_timer_ovf(src[0]), .port5_bit4(src[1]), .port5_bit5(src[2]),
        .counter_one_unf(src[3]), .counter_two_unf(src[4]), .hpw_timer_unf(src[5]),
        .lpw_timer_unf(src[6]), .port_change(src[7]), .core_req(core_req),
        .vector_take(vector_take), .vector_addr(vector_addr), .restore_valid(restore_valid),
        .restore_ctx(restore_ctx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
    core_model core_model_inst (.mclk(mclk), .arst_n(arst_n), .on_cmd(on_cmd),
        .off_cmd(off_cmd), .slow(slow), .svc_len(svc_len), .acc_seed(acc_seed),
        .st_seed(st_seed), .vector_take(vector_take), .core_req(core_req));

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        if (q.size() == 0) return 16'hxxxx;
        return q.pop_front();
    endfunction : pop

    task automatic bail(input string what);
        failures++;
        $display("wrong value %s: expected event seen none", what);
        stop_test();
    endtask : bail

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_rd.push_back({8'h00, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask : rd

    task automatic fall(input logic [7:0] f);
        src <= src & ~f;
        @(posedge mclk);
        src <= 8'hff;
        repeat (2) @(posedge mclk);
    endtask : fall

    task automatic wait_take();
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (vector_take !== 1'b1 && i < 100);
        if (i >= 100) bail("vector take");
    endtask : wait_take

    // Results are matched in the cycle they stand, oldest note first.
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (rd_d) chk("read data", pop(exp_rd), {8'h00, reg_rdata});
        if (vector_take === 1'b1) begin
            chk("vector", pop(exp_vec), {4'h0, vector_addr});
            exp_ctx.push_back({acc_seed, st_seed});
        end
        if (restore_valid === 1'b1) chk("context", pop(exp_ctx), restore_ctx);
    end

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        seed = 72775;
        failures = 0;
        n_compared = 0;
        {arst_n, on_cmd, off_cmd, slow, reg_wr, reg_rd} = 6'h00;
        src = 8'hff;
        svc_len = 4'h8;
        {acc_seed, st_seed, reg_wdata} = 24'h000000;
        reg_addr = 4'h0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(`IRQ_OFS_FLAG, 8'h00);
        rd(`IRQ_OFS_MASK, 8'h00);
        rd(`IRQ_OFS_STAT, 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        $display("done reset and map");
        for (k = 0; k < 8; k++) begin
            r = 8'($random(seed));
            m = 8'h01 << k;
            wr(`IRQ_OFS_MASK, r);
            rd(`IRQ_OFS_MASK, r);
            fall(m);
            rd(`IRQ_OFS_FLAG, r & m);
            chk("irq line", {15'h0, |(r & m)}, {15'h0, irq_out});
            wr(`IRQ_OFS_CLEAR, 8'hff);
        end
        $display("done sources and mask");
        wr(`IRQ_OFS_MASK, 8'hff);
        acc_seed <= 8'($random(seed));
        st_seed <= 8'($random(seed));
        svc_len <= {1'b1, 3'($random(seed))};
        slow <= 1'b1;
        exp_vec.push_back(16'h0009);
        exp_vec.push_back(16'h0012);
        exp_vec.push_back(16'h0018);
        fall(8'h24);
        rd(`IRQ_OFS_STAT, 8'h00);
        on_cmd <= 1'b1;
        @(posedge mclk);
        on_cmd <= 1'b0;
        wait_take();
        fall(8'h80);
        rd(`IRQ_OFS_STAT, 8'h23);
        wr(`IRQ_OFS_CLEAR, 8'h04);
        wait_take();
        wr(`IRQ_OFS_CLEAR, 8'h20);
        wait_take();
        wr(`IRQ_OFS_CLEAR, 8'h80);
        for (i = 0; i < 300 && exp_vec.size() + exp_ctx.size() != 0; i++) @(posedge mclk);
        if (i >= 300) bail("context restore");
        rd(`IRQ_OFS_FLAG, 8'h00);
        $display("done dispatch");
        off_cmd <= 1'b1;
        @(posedge mclk);
        off_cmd <= 1'b0;
        fall(8'h01);
        repeat (20) @(posedge mclk);
        rd(`IRQ_OFS_STAT, 8'h70);
        chk("irq line", 16'h0001, {15'h0, irq_out});
        wr(`IRQ_OFS_MASK, 8'h00);
        chk("irq line", 16'h0000, {15'h0, irq_out});
        wr(`IRQ_OFS_CLEAR, 8'h01);
        rd(`IRQ_OFS_FLAG, 8'h00);
        $display("done global disable");
        stop_test();
    end
endmodule : tb
